// File: core/sba_alu.sv
// Signed two's-complement arithmetic unit with an Avalon-MM slave port.
// Assumes one 10 MHz clock and a synchronous active-high reset.
//
// Behaviour
// RULE1: Word values are 16-bit, 8000 to 7fff.
// RULE2: Long values are 32-bit, 80000000 to 7fffffff.
// RULE3: Top bit is sign; two's complement throughout.
// RULE4: Negate, add, subtract, multiply, divide; word and long.
// RULE5: Carry set on carry out of addition.
// RULE6: Carry set on negative subtraction result.
// RULE7: Equals set when arithmetic result is zero.
// RULE8: Equals set when negation result is zero.
// RULE9: Overflow when word add/subtract exceeds 7fff.
// RULE10: Overflow when long add/subtract exceeds 7fffffff.
// RULE11: Underflow when word result below 8000.
// RULE12: Underflow when long result below 80000000.
// RULE13: Unmet flags cleared after every instruction.
// RULE14: Word instructions use only 16-bit operands.
// RULE15: Expansion instructions need an assigned table entry.
// RULE16: Table must be enabled before assigning entries; the code also takes entries in the same write that sets the enable bit.
// RULE17: Divide gives quotient and remainder; multiply double width.
// RULE18: Flags update together with the result.
`timescale 1ns/1ps
`default_nettype none

module sba_alu (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_o
);

    sba_pkg::sba_state_t s_q;
    sba_pkg::sba_state_t s_d;

    logic req;
    logic wr_ok;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic exec;
    sba_pkg::sba_instr_t instr;
    logic legal;
    logic allowed;
    logic lng;
    sba_pkg::sba_op_t op;

    logic signed [33:0] a_x;
    logic signed [33:0] b_x;
    logic signed [33:0] sum_x;
    logic signed [33:0] dif_x;
    logic signed [33:0] neg_x;
    logic signed [33:0] tr_x;
    logic signed [33:0] max_x;
    logic signed [33:0] min_x;
    logic signed [31:0] a32;
    logic signed [31:0] b32;
    logic signed [63:0] prod;
    logic signed [31:0] quo;
    logic signed [31:0] rem;
    logic [32:0] usum_l;
    logic [16:0] usum_w;
    logic ucarry;
    logic divzero;
    logic [31:0] r_lo;
    logic [31:0] r_hi;
    sba_pkg::sba_flags_t f_new;

    // Avalon handshake: one wait cycle on every access
    assign req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~s_q.ack;
    assign wr_ok = avs_write_i & s_q.ack;
    assign avs_readdata_o = s_q.rdata;
    assign irq_o = |(s_q.stat & s_q.mask);

    // Byte-lane merge for register writes
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wmask[gi*8 +: 8] = {8{avs_byteenable_i[gi]}};
        end
    endgenerate

    assign exec = wr_ok && avs_address_i == sba_pkg::OFS_COMMAND
        && avs_byteenable_i[0];
    assign instr = sba_pkg::sba_instr_t'(
        avs_writedata_i[sba_pkg::CMD_CODE_W-1:0]);
    assign legal = {28'h0, avs_writedata_i[sba_pkg::CMD_CODE_W-1:0]}
        < 32'(sba_pkg::NUM_INSTR);
    // Plain add and subtract words are always present
    assign allowed = legal && (instr == sba_pkg::add_word
        || instr == sba_pkg::subtract_word
        || s_q.optab[instr]); // RULE15

    always_comb begin
        lng = 1'b0;
        op = sba_pkg::op_add;
        case (instr)
            sba_pkg::negate_word: op = sba_pkg::op_negate;
            sba_pkg::add_word: op = sba_pkg::op_add;
            sba_pkg::subtract_word: op = sba_pkg::op_subtract;
            sba_pkg::signed_multiply_word: op = sba_pkg::op_multiply;
            sba_pkg::signed_divide_word: op = sba_pkg::op_divide;
            sba_pkg::negate_long: begin
                op = sba_pkg::op_negate;
                lng = 1'b1;
            end
            sba_pkg::add_long: begin
                op = sba_pkg::op_add;
                lng = 1'b1;
            end
            sba_pkg::subtract_long: begin
                op = sba_pkg::op_subtract;
                lng = 1'b1;
            end
            sba_pkg::signed_multiply_long: begin
                op = sba_pkg::op_multiply;
                lng = 1'b1;
            end
            sba_pkg::signed_divide_long: begin
                op = sba_pkg::op_divide;
                lng = 1'b1;
            end
            default: op = sba_pkg::op_add;
        endcase
    end

    // Sign-extended operands; word forms see only the low 16 bits
    assign a_x = lng ? {{2{s_q.opa[31]}}, s_q.opa}
        : {{18{s_q.opa[15]}}, s_q.opa[15:0]}; // RULE3 RULE14
    assign b_x = lng ? {{2{s_q.opb[31]}}, s_q.opb}
        : {{18{s_q.opb[15]}}, s_q.opb[15:0]}; // RULE3 RULE14
    assign max_x = lng ? sba_pkg::LONG_MAX : sba_pkg::WORD_MAX; // RULE1 RULE2
    assign min_x = lng ? sba_pkg::LONG_MIN : sba_pkg::WORD_MIN; // RULE1 RULE2

    // True results before truncation to the operand width
    assign sum_x = a_x + b_x;
    assign dif_x = a_x - b_x;
    assign neg_x = 34'sh0 - a_x;
    assign usum_l = {1'b0, s_q.opa} + {1'b0, s_q.opb};
    assign usum_w = {1'b0, s_q.opa[15:0]} + {1'b0, s_q.opb[15:0]};
    assign ucarry = lng ? usum_l[32] : usum_w[16];

    assign a32 = a_x[31:0];
    assign b32 = b_x[31:0];
    assign prod = a32 * b32; // RULE17
    assign divzero = b32 == 32'sh0;
    // Zero divisor and the one wrapping long case are pinned here
    always_comb begin
        if (divzero) begin
            quo = 32'sh0;
            rem = a32;
        end else if (lng && a32 == 32'sh8000_0000
                && b32 == 32'shffff_ffff) begin
            quo = a32;
            rem = 32'sh0;
        end else begin
            quo = a32 / b32; // RULE17
            rem = a32 % b32; // RULE17
        end
    end

    always_comb begin
        case (op)
            sba_pkg::op_negate: tr_x = neg_x;
            sba_pkg::op_subtract: tr_x = dif_x;
            default: tr_x = sum_x;
        endcase
    end

    // Results and flags of the instruction; all bits recomputed
    always_comb begin
        r_lo = sba_pkg::RST_WORD;
        r_hi = sba_pkg::RST_WORD;
        f_new = '0; // RULE13
        case (op)
            sba_pkg::op_multiply: begin
                if (lng) begin
                    r_lo = prod[31:0]; // RULE17
                    r_hi = prod[63:32];
                end else begin
                    r_lo = prod[31:0];
                end
                f_new.equals = prod == 64'sh0; // RULE7
            end
            sba_pkg::op_divide: begin
                if (lng) begin
                    r_lo = quo;
                    r_hi = rem; // RULE17
                end else begin
                    r_lo = {16'h0, quo[15:0]};
                    r_hi = {16'h0, rem[15:0]};
                end
                f_new.equals = r_lo == 32'h0; // RULE7
            end
            default: begin
                r_lo = lng ? tr_x[31:0] : {16'h0, tr_x[15:0]};
                f_new.equals = r_lo == 32'h0; // RULE7 RULE8
                if (op == sba_pkg::op_negate) begin
                    // Negating the most negative value falls off the range
                    f_new.underflow = tr_x > max_x; // RULE11 RULE12
                end else begin
                    f_new.underflow = tr_x < min_x; // RULE11 RULE12
                end
                if (op == sba_pkg::op_add) begin
                    f_new.carry = ucarry; // RULE5
                    f_new.overflow = tr_x > max_x; // RULE9 RULE10
                end else if (op == sba_pkg::op_subtract) begin
                    f_new.carry = dif_x < 34'sh0; // RULE6
                    f_new.overflow = tr_x > max_x; // RULE9 RULE10
                end
            end
        endcase
    end

    assign wval = avs_writedata_i & wmask;

    // Register file and execution
    always_comb begin
        s_d = s_q;
        s_d.ack = req & ~s_q.ack;
        if (req && !s_q.ack && avs_read_i) begin
            if (avs_address_i == sba_pkg::OFS_OPERAND_A) begin
                s_d.rdata = s_q.opa;
            end else if (avs_address_i == sba_pkg::OFS_OPERAND_B) begin
                s_d.rdata = s_q.opb;
            end else if (avs_address_i == sba_pkg::OFS_RESULT_LO) begin
                s_d.rdata = s_q.res_lo;
            end else if (avs_address_i == sba_pkg::OFS_RESULT_HI) begin
                s_d.rdata = s_q.res_hi;
            end else if (avs_address_i == sba_pkg::OFS_FLAGS) begin
                s_d.rdata = {28'h0, s_q.flags};
            end else if (avs_address_i == sba_pkg::OFS_IRQ_STATUS) begin
                s_d.rdata = {29'h0, s_q.stat};
            end else if (avs_address_i == sba_pkg::OFS_IRQ_MASK) begin
                s_d.rdata = {29'h0, s_q.mask};
            end else if (avs_address_i == sba_pkg::OFS_OPTABLE) begin
                s_d.rdata = {s_q.tab_en, 21'h0, s_q.optab};
            end else begin
                s_d.rdata = 32'h0000_0000;
            end
        end
        if (wr_ok) begin
            if (avs_address_i == sba_pkg::OFS_OPERAND_A) begin
                s_d.opa = (s_q.opa & ~wmask) | wval;
            end else if (avs_address_i == sba_pkg::OFS_OPERAND_B) begin
                s_d.opb = (s_q.opb & ~wmask) | wval;
            end else if (avs_address_i == sba_pkg::OFS_IRQ_STATUS) begin
                s_d.stat = s_q.stat & ~wval[sba_pkg::NUM_IRQ-1:0];
            end else if (avs_address_i == sba_pkg::OFS_IRQ_MASK) begin
                s_d.mask = (s_q.mask & ~wmask[sba_pkg::NUM_IRQ-1:0])
                    | wval[sba_pkg::NUM_IRQ-1:0];
            end else if (avs_address_i == sba_pkg::OFS_OPTABLE) begin
                if (avs_byteenable_i[3]) begin
                    s_d.tab_en = avs_writedata_i[sba_pkg::TAB_ENABLE_BIT];
                end
                // Entries change only if the table is enabled once this write's enable bit is applied
                if (s_d.tab_en) begin
                    s_d.optab = (s_q.optab & ~wmask[9:0]) | wval[9:0]; // RULE16
                end
            end
        end
        if (exec) begin
            if (allowed) begin
                s_d.res_lo = r_lo; // RULE4 RULE18
                s_d.res_hi = r_hi;
                s_d.flags = f_new; // RULE13 RULE18
                s_d.stat[sba_pkg::IRQ_DONE] = 1'b1;
                if (op == sba_pkg::op_divide && divzero) begin
                    s_d.stat[sba_pkg::IRQ_DIVZERO] = 1'b1;
                end
            end else begin
                s_d.stat[sba_pkg::IRQ_ILLEGAL] = 1'b1; // RULE15
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
            s_q.optab <= sba_pkg::RST_OPTABLE;
            s_q.mask <= sba_pkg::RST_IRQ_MASK;
        end else begin
            s_q <= s_d;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence held_req_s;
        req && avs_waitrequest_o ##1 req;
    endsequence

    sequence word_add_s;
        exec && allowed && instr == sba_pkg::add_word;
    endsequence

    sequence long_sub_s;
        exec && allowed && instr == sba_pkg::subtract_long;
    endsequence

    sequence long_add_s;
        exec && allowed && instr == sba_pkg::add_long;
    endsequence

    sequence neg_min_s;
        exec && allowed && op == sba_pkg::op_negate && a_x == min_x;
    endsequence

    wait_one_cycle_a: assert property (held_req_s |-> !avs_waitrequest_o)
        else $error("waitrequest not released after one cycle");

    add_carry_out_a: assert property ( // RULE5
        word_add_s |=> s_q.flags.carry == $past(usum_w[16]))
        else $error("carry of word add wrong");

    sub_borrow_flag_a: assert property ( // RULE6
        long_sub_s |=> s_q.flags.carry == ($signed($past(s_q.opa))
            < $signed($past(s_q.opb))))
        else $error("borrow of long subtract wrong");

    equals_zero_a: assert property ( // RULE7
        exec && allowed && instr != sba_pkg::signed_multiply_long
        |=> s_q.flags.equals == (s_q.res_lo == 32'h0))
        else $error("equals flag does not match result");

    word_overflow_a: assert property ( // RULE9
        word_add_s ##0 (s_q.opa[15] == s_q.opb[15])
        ##0 (usum_w[15] != s_q.opa[15]) ##0 !s_q.opa[15]
        |=> s_q.flags.overflow && !s_q.flags.underflow)
        else $error("word overflow missed");

    long_underflow_a: assert property ( // RULE12
        long_sub_s ##0 s_q.opa[31] && !s_q.opb[31]
        ##0 !dif_x[31] |=> s_q.flags.underflow && s_q.flags.carry)
        else $error("long underflow missed");

    mult_flags_clear_a: assert property ( // RULE13
        exec && allowed && op == sba_pkg::op_multiply
        |=> !s_q.flags.carry && !s_q.flags.overflow
            && !s_q.flags.underflow)
        else $error("stale flag after multiply");

    table_gate_a: assert property ( // RULE15
        exec && !allowed |=> $stable(s_q.res_lo) && $stable(s_q.flags)
            && s_q.stat[sba_pkg::IRQ_ILLEGAL])
        else $error("unassigned instruction executed");

    word_width_a: assert property ( // RULE14
        exec && allowed && !lng && op != sba_pkg::op_multiply
        |=> s_q.res_lo[31:16] == 16'h0 && s_q.res_hi[31:16] == 16'h0)
        else $error("word result wider than 16 bits");

    irq_follows_a: assert property (
        exec && allowed && s_q.mask[sba_pkg::IRQ_DONE] |=> irq_o)
        else $error("done interrupt not raised");

    neg_limit_a: assert property ( // RULE11
        neg_min_s |=> s_q.flags.underflow && !s_q.flags.overflow
            && !s_q.flags.equals)
        else $error("negate of most negative value not flagged");

    long_overflow_a: assert property ( // RULE10
        long_add_s ##0 (!s_q.opa[31] && !s_q.opb[31])
        ##0 usum_l[31] |=> s_q.flags.overflow && !s_q.flags.carry)
        else $error("long overflow missed");

    neg_zero_a: assert property ( // RULE8
        exec && allowed && op == sba_pkg::op_negate && a_x == 34'sh0
        |=> s_q.flags.equals && s_q.res_lo == 32'h0)
        else $error("equals missed on zero negation");

    div_zero_a: assert property ( // RULE7
        exec && allowed && op == sba_pkg::op_divide && divzero
        |=> s_q.stat[sba_pkg::IRQ_DIVZERO] && s_q.flags.equals)
        else $error("divide by zero not reported");

endmodule : sba_alu

`default_nettype wire

// File: core/sba_pkg.sv
// Package of the signed binary arithmetic unit: register map, field
// positions, reset values, instruction codes and the state carrier.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package sba_pkg;

    // Register byte offsets
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFS_OPERAND_A = 6'h00;
    localparam logic [5:0] OFS_OPERAND_B = 6'h04;
    localparam logic [5:0] OFS_COMMAND = 6'h08;
    localparam logic [5:0] OFS_RESULT_LO = 6'h0c;
    localparam logic [5:0] OFS_RESULT_HI = 6'h10;
    localparam logic [5:0] OFS_FLAGS = 6'h14;
    localparam logic [5:0] OFS_IRQ_STATUS = 6'h18;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h1c;
    localparam logic [5:0] OFS_OPTABLE = 6'h20;

    // Field positions
    localparam int FLG_CARRY = 0;
    localparam int FLG_EQUALS = 1;
    localparam int FLG_OVERFLOW = 2;
    localparam int FLG_UNDERFLOW = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ILLEGAL = 1;
    localparam int IRQ_DIVZERO = 2;
    localparam int TAB_ENABLE_BIT = 31;
    localparam int CMD_CODE_W = 4;
    localparam int NUM_INSTR = 10;
    localparam int NUM_IRQ = 3;

    // Reset values
    localparam logic [9:0] RST_OPTABLE = 10'h000;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Signed ranges at the internal 34-bit width
    localparam logic signed [33:0] WORD_MAX = 34'sh0_0000_7fff;
    localparam logic signed [33:0] WORD_MIN = 34'sh3_ffff_8000;
    localparam logic signed [33:0] LONG_MAX = 34'sh0_7fff_ffff;
    localparam logic signed [33:0] LONG_MIN = 34'sh3_8000_0000;

    // Instruction codes; the code is also the bit in the opcode table
    typedef enum logic [3:0] {
        negate_word,
        add_word,
        subtract_word,
        signed_multiply_word,
        signed_divide_word,
        negate_long,
        add_long,
        subtract_long,
        signed_multiply_long,
        signed_divide_long
    } sba_instr_t;

    typedef enum logic [2:0] {
        op_negate,
        op_add,
        op_subtract,
        op_multiply,
        op_divide
    } sba_op_t;

    typedef struct packed {
        logic underflow;
        logic overflow;
        logic equals;
        logic carry;
    } sba_flags_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [31:0] opa;
        logic [31:0] opb;
        logic [31:0] res_lo;
        logic [31:0] res_hi;
        sba_flags_t flags;
        logic [2:0] stat;
        logic [2:0] mask;
        logic tab_en;
        logic [9:0] optab;
    } sba_state_t;

endpackage : sba_pkg

// File: dv/sba_alu_tb.sv
// Self-checking bench for the signed arithmetic unit over its Avalon port.
// Assumes one wait state per access, as the unit's hand-over states.
`timescale 1ns/1ps
`default_nettype none

module sba_alu_tb;

    typedef struct packed {
        logic [3:0] op;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] lo;
        logic [31:0] hi;
        logic [3:0] f;
    } sba_case_t;

    logic sys_clk;
    logic sys_rst;
    logic [5:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] avs_byteenable;
    logic irq;
    int fails;
    int checks;

    // Operation, operands, expected low, high and flags {uf,ov,eq,cy}
    sba_case_t cases [0:23] = '{
        '{4'h1, 32'h1234_7fff, 32'hffff_0001, 32'h0000_8000, 32'h0, 4'h4},
        '{4'h1, 32'h0000_ffff, 32'h0000_0001, 32'h0, 32'h0, 4'h3},
        '{4'h1, 32'h0000_8000, 32'h0000_ffff, 32'h0000_7fff, 32'h0, 4'h9},
        '{4'h2, 32'h3, 32'h5, 32'h0000_fffe, 32'h0, 4'h1},
        '{4'h2, 32'h8000, 32'h1, 32'h0000_7fff, 32'h0, 4'h9},
        '{4'h2, 32'h7fff, 32'hffff, 32'h0000_8000, 32'h0, 4'h4},
        '{4'h2, 32'h5, 32'h5, 32'h0, 32'h0, 4'h2},
        '{4'h0, 32'h8000, 32'h0, 32'h0000_8000, 32'h0, 4'h8},
        '{4'h0, 32'h0, 32'h0, 32'h0, 32'h0, 4'h2},
        '{4'h0, 32'h5, 32'h0, 32'h0000_fffb, 32'h0, 4'h0},
        '{4'h3, 32'h8000, 32'h8000, 32'h4000_0000, 32'h0, 4'h0},
        '{4'h3, 32'hfffe, 32'h3, 32'hffff_fffa, 32'h0, 4'h0},
        '{4'h4, 32'hfff9, 32'h2, 32'h0000_fffd, 32'h0000_ffff, 4'h0},
        '{4'h4, 32'h3, 32'h7, 32'h0, 32'h3, 4'h2},
        '{4'h5, 32'h8000_0000, 32'h0, 32'h8000_0000, 32'h0, 4'h8},
        '{4'h6, 32'h7fff_ffff, 32'h1, 32'h8000_0000, 32'h0, 4'h4},
        '{4'h6, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_fffe, 32'h0, 4'h1},
        '{4'h7, 32'h8000_0000, 32'h1, 32'h7fff_ffff, 32'h0, 4'h9},
        '{4'h7, 32'h1, 32'h1, 32'h0, 32'h0, 4'h2},
        '{4'h8, 32'hffff_ffff, 32'hffff_ffff, 32'h1, 32'h0, 4'h0},
        '{4'h8, 32'h8000_0000, 32'h2, 32'h0, 32'hffff_ffff, 4'h0},
        '{4'h9, 32'hffff_fff9, 32'h2, 32'hffff_fffd, 32'hffff_ffff, 4'h0},
        '{4'h9, 32'h0, 32'h5, 32'h0, 32'h0, 4'h2},
        '{4'h9, 32'h5, 32'h0, 32'h0, 32'h5, 4'h2}
    };

    sba_alu sba_alu_inst (
        .sys_clk_i(sys_clk),
        .sys_rst_i(sys_rst),
        .avs_address_i(avs_address),
        .avs_read_i(avs_read),
        .avs_write_i(avs_write),
        .avs_writedata_i(avs_writedata),
        .avs_byteenable_i(avs_byteenable),
        .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(avs_waitrequest),
        .irq_o(irq)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        checks++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // One access; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) chk("waitrequest", 32'h0, 32'h1);
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [5:0] a, input logic [31:0] e,
                       input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask : rdc

    task automatic irq_chk(input logic e);
        @(negedge sys_clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : irq_chk

    task automatic test_done;
        if (fails == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (5000) @(posedge sys_clk);
        fails++;
        test_done();
    end

    initial begin
        fails = 0;
        checks = 0;
        sys_rst = 1'b1;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        irq_chk(1'b0);
        rdc(sba_pkg::OFS_FLAGS, 32'h0, "flags reset");
        rdc(sba_pkg::OFS_IRQ_MASK, 32'h0, "mask reset");
        rdc(sba_pkg::OFS_OPTABLE, 32'h0, "table reset");
        rdc(sba_pkg::OFS_RESULT_LO, 32'h0, "result reset");
        rdc(6'h24, 32'h0, "unmapped");
        // Plain add works with an empty table
        wr(sba_pkg::OFS_OPERAND_A, 32'h0000_0005);
        wr(sba_pkg::OFS_OPERAND_B, 32'h0000_fffb);
        wr(sba_pkg::OFS_COMMAND, 32'h1);
        rdc(sba_pkg::OFS_FLAGS, 32'h3, "flags empty table");
        // Unassigned expansion op and bad code are refused
        wr(sba_pkg::OFS_COMMAND, 32'h3);
        rdc(sba_pkg::OFS_RESULT_LO, 32'h0, "refused result");
        rdc(sba_pkg::OFS_FLAGS, 32'h3, "refused flags");
        rdc(sba_pkg::OFS_IRQ_STATUS, 32'h3, "illegal status");
        wr(sba_pkg::OFS_IRQ_STATUS, 32'h2);
        wr(sba_pkg::OFS_COMMAND, 32'ha);
        rdc(sba_pkg::OFS_IRQ_STATUS, 32'h3, "bad code status");
        // Entries only stick once the table is enabled
        wr(sba_pkg::OFS_OPTABLE, 32'h0000_03ff);
        rdc(sba_pkg::OFS_OPTABLE, 32'h0, "table locked");
        wr(sba_pkg::OFS_OPTABLE, 32'h8000_03ff);
        rdc(sba_pkg::OFS_OPTABLE, 32'h8000_03ff, "table set");
        foreach (cases[i]) begin
            wr(sba_pkg::OFS_OPERAND_A, cases[i].a);
            wr(sba_pkg::OFS_OPERAND_B, cases[i].b);
            wr(sba_pkg::OFS_COMMAND, {28'h0, cases[i].op});
            rdc(sba_pkg::OFS_RESULT_LO, cases[i].lo, "result lo");
            rdc(sba_pkg::OFS_RESULT_HI, cases[i].hi, "result hi");
            rdc(sba_pkg::OFS_FLAGS, {28'h0, cases[i].f}, "flags");
        end
        rdc(sba_pkg::OFS_OPERAND_A, 32'h5, "operand a");
        rdc(sba_pkg::OFS_COMMAND, 32'h0, "command read");
        // Byte lanes: low half of operand B only; no lane 0, no execute
        avs_byteenable <= 4'h3;
        wr(sba_pkg::OFS_OPERAND_B, 32'hffff_ffff);
        avs_byteenable <= 4'he;
        wr(sba_pkg::OFS_COMMAND, 32'h1);
        avs_byteenable <= 4'hf;
        rdc(sba_pkg::OFS_OPERAND_B, 32'h0000_ffff, "operand b lanes");
        rdc(sba_pkg::OFS_RESULT_LO, 32'h0, "no lane zero");
        // Interrupt: all three events pending, mask decides the line
        rdc(sba_pkg::OFS_IRQ_STATUS, 32'h7, "irq status");
        irq_chk(1'b0);
        wr(sba_pkg::OFS_IRQ_MASK, 32'h1);
        irq_chk(1'b1);
        wr(sba_pkg::OFS_IRQ_STATUS, 32'h1);
        irq_chk(1'b0);
        wr(sba_pkg::OFS_IRQ_MASK, 32'h6);
        irq_chk(1'b1);
        wr(sba_pkg::OFS_IRQ_STATUS, 32'h7);
        irq_chk(1'b0);
        rdc(sba_pkg::OFS_IRQ_STATUS, 32'h0, "irq cleared");
        // Done event raises the line while it is unmasked
        wr(sba_pkg::OFS_IRQ_MASK, 32'h1);
        wr(sba_pkg::OFS_COMMAND, 32'h1);
        irq_chk(1'b1);
        rdc(sba_pkg::OFS_RESULT_LO, 32'h0000_0004, "add after lanes");
        rdc(sba_pkg::OFS_FLAGS, 32'h1, "carry after lanes");
        wr(sba_pkg::OFS_IRQ_STATUS, 32'h1);
        irq_chk(1'b0);
        test_done();
    end

endmodule : sba_alu_tb

`default_nettype wire
